// >>> src/fcs_host.sv
// host controller that issues sequencer commands over the device register port
`timescale 1ns/100ps
module fcs_host #(
	parameter logic [19:0] POLL_LIMIT = 20'd100000
) (
	input  wire logic                  clk_in,       // 100 MHz clock
	input  wire logic                  reset_n_in,   // async reset, low
	input  wire fcs_pkg::fcs_sreq_type sw_req_in,    // software access
	output logic [31:0]                sw_rdata_out, // software read data
	output fcs_pkg::fcs_dreq_type      dev_req_out,  // device access
	input  wire logic [31:0]           dev_rdata_in  // device read data
);
	typedef enum {S_IDLE, S_ENTRY, S_SADDR, S_EADDR, S_DIR, S_CODE, S_CNT,
		S_DBF, S_DATA, S_FINAL, S_RD, S_RWAIT, S_RCHK, S_FSTOP, S_EXIT} fcs_st_type;
	typedef enum {K_AREA_PROGRAMMED_COMPLETION_FLAG, K_TAG, K_DBF, K_RDY, K_LOCK, K_BLANK_CHECK_RESULT_BIT, K_PADDR,
		K_NONE, K_STOP} fcs_ck_type;

	fcs_st_type            st_q, st_d;
	fcs_ck_type            ck_q, ck_d;
	fcs_pkg::fcs_op_type   op_q, op_d;
	fcs_pkg::fcs_dreq_type req_q, req_d;
	logic [2:0]            idx_q, idx_d;
	logic [19:0]           cnt_q, cnt_d;
	logic                  done_q, done_d;
	logic                  ref_q, ref_d;
	logic                  tmo_q, tmo_d;
	logic                  lck_q, lck_d;
	logic                  nbl_q, nbl_d;
	logic                  chk_q, chk_d;
	logic [2:0]            set_q, set_d;
	logic [31:0]           pa_q, pa_d;
	logic [31:0]           sa_q, sa_d;
	logic [31:0]           ea_q, ea_d;
	logic                  dir_q, dir_d;
	logic [31:0]           dat_q [8];
	logic [31:0]           dat_d [8];
	logic [31:0]           rd_q, rd_d;
	logic                  busy;
	logic                  go;

	function automatic fcs_pkg::fcs_dreq_type wr(input logic [31:0] a, input logic [31:0] d);
		fcs_pkg::fcs_dreq_type r;
		r.we = 1'b1;
		r.re = 1'b0;
		r.addr = a;
		r.wdata = d;
		return r;
	endfunction : wr

	function automatic fcs_pkg::fcs_dreq_type rd(input logic [31:0] a);
		fcs_pkg::fcs_dreq_type r;
		r.we = 1'b0;
		r.re = 1'b1;
		r.addr = a;
		r.wdata = '0;
		return r;
	endfunction : rd

	function automatic logic [31:0] cmd(input logic [7:0] c);
		return {24'h000000, c};
	endfunction : cmd

	function automatic logic [7:0] code_of(input fcs_pkg::fcs_op_type o);
		unique case (o)
			fcs_pkg::OP_BCHK:   return fcs_pkg::CODE_BCHK;
			fcs_pkg::OP_PPRG:   return fcs_pkg::CODE_PPRG;
			fcs_pkg::OP_PERS:   return fcs_pkg::CODE_PERS;
			fcs_pkg::OP_SWERS:  return fcs_pkg::CODE_SWERS;
			fcs_pkg::OP_SWPRG:  return fcs_pkg::CODE_SWPRG;
			fcs_pkg::OP_TAGERS: return fcs_pkg::CODE_TAGER;
			fcs_pkg::OP_TAGUPD: return fcs_pkg::CODE_TAGUP;
			fcs_pkg::OP_FSTOP:  return fcs_pkg::CODE_FSTOP;
		endcase
	endfunction : code_of

	function automatic logic [31:0] ck_addr(input fcs_ck_type k);
		unique case (k)
			K_AREA_PROGRAMMED_COMPLETION_FLAG, K_TAG:       return fcs_pkg::DEV_SWFLAG;
			K_DBF, K_RDY, K_STOP: return fcs_pkg::DEV_FSTAT;
			K_LOCK:              return fcs_pkg::DEV_ASTAT;
			K_BLANK_CHECK_RESULT_BIT:              return fcs_pkg::DEV_BCSTAT;
			K_PADDR:             return fcs_pkg::DEV_PADDR;
			K_NONE:              return fcs_pkg::DEV_CMDWIN;
		endcase
	endfunction : ck_addr

	function automatic logic dir_ok(input logic [31:0] s, input logic [31:0] e, input logic d);
		return d ? (s >= e) : (s <= e);
	endfunction : dir_ok

	function automatic logic area_ok(input logic [31:0] s, input logic [31:0] e);
		return (s >> fcs_pkg::AREA_SHIFT) == (e >> fcs_pkg::AREA_SHIFT);
	endfunction : area_ok

	function automatic logic is_prg(input fcs_pkg::fcs_op_type o);
		return o == fcs_pkg::OP_PPRG || o == fcs_pkg::OP_SWPRG;
	endfunction : is_prg

	assign busy = st_q != S_IDLE;
	assign go = sw_req_in.we && sw_req_in.addr == fcs_pkg::SW_CTRL && sw_req_in.wdata[fcs_pkg::GO_BIT] && !busy;
	assign dev_req_out = req_q;
	assign sw_rdata_out = rd_q;

	// software side: command setup and read back
	always_comb begin
		sa_d = sa_q;
		ea_d = ea_q;
		dir_d = dir_q;
		dat_d = dat_q;
		rd_d = '0;
		if (sw_req_in.we && !busy) begin
			if (sw_req_in.addr == fcs_pkg::SW_SADDR) sa_d = sw_req_in.wdata;
			if (sw_req_in.addr == fcs_pkg::SW_EADDR) ea_d = sw_req_in.wdata;
			if (sw_req_in.addr == fcs_pkg::SW_DIR) dir_d = sw_req_in.wdata[0];
			if (sw_req_in.addr[7:5] == fcs_pkg::SW_DATA[7:5]) dat_d[sw_req_in.addr[4:2]] = sw_req_in.wdata;
		end
		if (sw_req_in.re) begin
			unique case (sw_req_in.addr)
				fcs_pkg::SW_SADDR: rd_d = sa_q;
				fcs_pkg::SW_EADDR: rd_d = ea_q;
				fcs_pkg::SW_DIR:   rd_d = {31'h00000000, dir_q};
				fcs_pkg::SW_STAT:  rd_d = {26'h0000000, nbl_q, lck_q, tmo_q, ref_q, done_q, busy};
				fcs_pkg::SW_PADDR: rd_d = pa_q;
				default:           rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sa_q <= '0;
			ea_q <= '0;
			dir_q <= 1'b0;
			dat_q <= '{default: '0};
			rd_q <= '0;
		end else begin
			sa_q <= sa_d;
			ea_q <= ea_d;
			dir_q <= dir_d;
			dat_q <= dat_d;
			rd_q <= rd_d;
		end
	end

	// command sequencer
	always_comb begin
		st_d = st_q;
		ck_d = ck_q;
		op_d = op_q;
		idx_d = idx_q;
		cnt_d = cnt_q;
		done_d = done_q;
		ref_d = ref_q;
		tmo_d = tmo_q;
		lck_d = lck_q;
		nbl_d = nbl_q;
		chk_d = chk_q;
		set_d = set_q;
		pa_d = pa_q;
		req_d = '0;
		unique case (st_q)
			S_IDLE: begin
				cnt_d = '0;
				if (go) begin
					op_d = fcs_pkg::fcs_op_type'(sw_req_in.wdata[2:0]);
					{done_d, ref_d, tmo_d, lck_d, nbl_d, chk_d} = '0;
					set_d = '0;
					if (op_d == fcs_pkg::OP_BCHK && !(dir_ok(sa_q, ea_q, dir_q) && area_ok(sa_q, ea_q))) begin
						ref_d = 1'b1; // R08 R10
						done_d = 1'b1;
					end else if (op_d == fcs_pkg::OP_SWERS) begin
						ck_d = K_AREA_PROGRAMMED_COMPLETION_FLAG; // R19
						st_d = S_RD;
					end else if (op_d == fcs_pkg::OP_TAGERS) begin
						ck_d = K_TAG; // R21
						st_d = S_RD;
					end else begin
						st_d = S_ENTRY;
					end
				end
			end
			S_ENTRY: begin
				req_d = wr(fcs_pkg::DEV_ENTRY, fcs_pkg::ENTRY_PE); // R24
				st_d = op_q == fcs_pkg::OP_FSTOP ? S_FSTOP : S_SADDR;
			end
			S_SADDR: begin
				req_d = wr(fcs_pkg::DEV_SADDR, sa_q); // R07 R15 R16 R19 R20 R21 R22
				set_d[0] = 1'b1;
				st_d = op_q == fcs_pkg::OP_BCHK ? S_EADDR : S_CODE;
			end
			S_EADDR: begin
				req_d = wr(fcs_pkg::DEV_EADDR, ea_q); // R07
				set_d[1] = 1'b1;
				st_d = S_DIR;
			end
			S_DIR: begin
				req_d = wr(fcs_pkg::DEV_BCCTL, {31'h00000000, dir_q}); // R07
				set_d[2] = 1'b1;
				st_d = S_CODE;
			end
			S_CODE: begin
				req_d = wr(fcs_pkg::DEV_CMDWIN, cmd(code_of(op_q))); // R11 R16 R19 R21 R22
				st_d = is_prg(op_q) ? S_CNT : S_FINAL;
			end
			S_CNT: begin
				req_d = wr(fcs_pkg::DEV_CMDWIN, cmd(fcs_pkg::PRG_WORDS)); // R15 R20
				idx_d = '0;
				st_d = S_DBF;
			end
			S_DBF: begin
				ck_d = K_DBF;
				st_d = S_RD;
			end
			S_DATA: begin
				req_d = wr(fcs_pkg::DEV_CMDWIN, dat_q[idx_q]); // R15 R20
				idx_d = idx_q + 3'h1;
				st_d = idx_q == fcs_pkg::LAST_IDX ? S_FINAL : S_DBF;
			end
			S_FINAL: begin
				req_d = wr(fcs_pkg::DEV_CMDWIN, cmd(fcs_pkg::CODE_FINAL)); // R11 R15 R16 R20 R26
				cnt_d = '0;
				ck_d = K_RDY; // R12 R27
				st_d = S_RD;
			end
			S_RD: begin
				req_d = rd(ck_addr(ck_q)); // R04
				st_d = S_RWAIT;
			end
			S_RWAIT: st_d = S_RCHK;
			S_RCHK: begin
				st_d = S_RD;
				unique case (ck_q)
					K_AREA_PROGRAMMED_COMPLETION_FLAG, K_TAG: begin
						if (ck_q == K_AREA_PROGRAMMED_COMPLETION_FLAG ? dev_rdata_in[fcs_pkg::AREA_PROGRAMMED_COMPLETION_FLAG_BIT]
								: &dev_rdata_in[fcs_pkg::TAG_HI:fcs_pkg::TAG_LO]) begin
							chk_d = 1'b1; // R19 R21
							st_d = S_ENTRY;
						end else begin
							ref_d = 1'b1; // R18
							done_d = 1'b1;
							st_d = S_IDLE;
						end
					end
					K_DBF, K_RDY, K_STOP: begin
						if (ck_q == K_DBF ? !dev_rdata_in[fcs_pkg::DBF_BIT] : dev_rdata_in[fcs_pkg::RDY_BIT]) begin
							cnt_d = '0;
							unique case (ck_q)
								K_DBF: st_d = S_DATA;
								K_RDY: ck_d = K_LOCK; // R12
								default: st_d = S_EXIT;
							endcase
						end else if (cnt_q == POLL_LIMIT) begin
							tmo_d = 1'b1;
							if (ck_q == K_STOP) begin
								st_d = S_EXIT;
							end else begin
								ck_d = K_NONE; // R05
							end
						end else begin
							cnt_d = cnt_q + 20'h00001;
						end
					end
					K_LOCK: begin
						if (dev_rdata_in[fcs_pkg::LOCK_BIT]) begin
							lck_d = 1'b1; // R03 R09
							st_d = S_FSTOP;
						end else if (op_q == fcs_pkg::OP_BCHK) begin
							ck_d = K_BLANK_CHECK_RESULT_BIT;
						end else begin
							st_d = S_EXIT;
						end
					end
					K_BLANK_CHECK_RESULT_BIT: begin
						nbl_d = dev_rdata_in[fcs_pkg::BLANK_CHECK_RESULT_BIT_BIT]; // R12 R14
						if (dev_rdata_in[fcs_pkg::BLANK_CHECK_RESULT_BIT_BIT]) begin
							ck_d = K_PADDR;
						end else begin
							st_d = S_EXIT;
						end
					end
					K_PADDR: begin
						pa_d = dev_rdata_in; // R13
						st_d = S_EXIT;
					end
					K_NONE: st_d = S_FSTOP; // R05
				endcase
			end
			S_FSTOP: begin
				req_d = wr(fcs_pkg::DEV_CMDWIN, cmd(fcs_pkg::CODE_FSTOP)); // R01 R03 R23
				cnt_d = '0;
				ck_d = K_STOP;
				st_d = S_RD;
			end
			S_EXIT: begin
				req_d = wr(fcs_pkg::DEV_ENTRY, fcs_pkg::ENTRY_RD);
				done_d = 1'b1;
				st_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q <= S_IDLE;
			ck_q <= K_NONE;
			op_q <= fcs_pkg::OP_FSTOP;
			req_q <= '0;
			idx_q <= '0;
			cnt_q <= '0;
			done_q <= 1'b0;
			ref_q <= 1'b0;
			tmo_q <= 1'b0;
			lck_q <= 1'b0;
			nbl_q <= 1'b0;
			chk_q <= 1'b0;
			set_q <= '0;
			pa_q <= '0;
		end else begin
			st_q <= st_d;
			ck_q <= ck_d;
			op_q <= op_d;
			req_q <= req_d;
			idx_q <= idx_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			ref_q <= ref_d;
			tmo_q <= tmo_d;
			lck_q <= lck_d;
			nbl_q <= nbl_d;
			chk_q <= chk_d;
			set_q <= set_d;
			pa_q <= pa_d;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_cmd(logic [7:0] c);
		dev_req_out.we && dev_req_out.addr == fcs_pkg::DEV_CMDWIN && dev_req_out.wdata[7:0] == c;
	endsequence
	sequence s_win_read;
		dev_req_out.re && dev_req_out.addr == fcs_pkg::DEV_CMDWIN;
	endsequence

	a_tmo_lock_stop: assert property ($rose(tmo_q) && ck_q == K_NONE |-> ##1 s_win_read ##3 s_cmd(fcs_pkg::CODE_FSTOP)) // R05
		else $error("timeout not followed by window read and forced stop");
	a_setup_first: assert property (s_cmd(fcs_pkg::CODE_BCHK) |-> set_q == 3'h7) // R07
		else $error("blank check issued before range setup");
	a_range_dir: assert property (s_cmd(fcs_pkg::CODE_BCHK) |-> dir_ok(sa_q, ea_q, dir_q)) // R08
		else $error("blank check range against direction");
	a_one_area: assert property (s_cmd(fcs_pkg::CODE_BCHK) |-> area_ok(sa_q, ea_q)) // R10
		else $error("blank check range crosses an area");
	a_bchk_pair: assert property (st_q == S_CODE && op_q == fcs_pkg::OP_BCHK
			|=> s_cmd(fcs_pkg::CODE_BCHK) ##1 s_cmd(fcs_pkg::CODE_FINAL)) // R11
		else $error("blank check codes out of order");
	a_prop_words: assert property (st_q == S_CNT && op_q == fcs_pkg::OP_PPRG
			|-> ##36 st_q == S_DBF && idx_q == 3'h7) // R15
		else $error("property program word pacing wrong");
	a_perase_pair: assert property (st_q == S_CODE && op_q == fcs_pkg::OP_PERS
			|=> s_cmd(fcs_pkg::CODE_PERS) ##1 s_cmd(fcs_pkg::CODE_FINAL)) // R16
		else $error("property erase codes out of order");
	a_area_programmed_completion_flag_first: assert property (s_cmd(fcs_pkg::CODE_SWERS) |-> chk_q && op_q == fcs_pkg::OP_SWERS) // R19
		else $error("switch erase without completion check");
	a_final_last: assert property (st_q == S_FINAL && is_prg(op_q) |-> $past(st_q) == S_DATA && idx_q == 3'h0) // R20
		else $error("final code before all data words");
	a_tag_first: assert property (s_cmd(fcs_pkg::CODE_TAGER) |-> chk_q) // R21
		else $error("tag erase without flag check");
	a_tag_pair: assert property (st_q == S_CODE && op_q == fcs_pkg::OP_TAGUPD
			|=> s_cmd(fcs_pkg::CODE_TAGUP) ##1 s_cmd(fcs_pkg::CODE_FINAL)) // R22
		else $error("tag update codes out of order");
endmodule : fcs_host

// >>> src/fcs_pkg.sv
// constants, offsets and carrier types of the flash command sequencer host
// How it works
// R01: forced stop aborts the running command
// R02: aborted program or erase counts one cycle
// R03: forced stop resets core and status registers
// R04: any command window read forces lock
// R05: on timeout read window, then forced stop
// R06: erased unprogrammed flash reads all ones
// R07: load direction, start, end before check
// R08: start and end ordered per direction bit
// R09: inconsistent range flags error and locks
// R10: blank check range stays in one area
// R11: codes 71h then d0h start blank check
// R12: ready flag and result bit report check
// R13: first nonblank address goes to register
// R14: trust blank check only after clean erase
// R15: property program 32-byte units, ends d0h
// R16: codes 47h then d0h erase property back
// R17: valid-area flags select front sides
// R18: incomplete update refuses switching steps
// R19: check completion flag, then 87h d0h
// R20: switch program 32-byte units, ends d0h
// R21: check tag flags, then 89h d0h
// R22: codes 83h then d0h update tag
// R23: forced stop accepted whatever ready shows
// R24: read mode rejects all but status clear
// R25: command in lock sets illegal error
// R26: last access not d0h is illegal
// R27: ready clears on accept, sets on finish
package fcs_pkg;
	// device register map
	localparam logic [31:0] DEV_CMDWIN = 32'h0000_0000;
	localparam logic [31:0] DEV_SADDR  = 32'h0000_0004;
	localparam logic [31:0] DEV_EADDR  = 32'h0000_0008;
	localparam logic [31:0] DEV_BCCTL  = 32'h0000_000c;
	localparam logic [31:0] DEV_FSTAT  = 32'h0000_0010;
	localparam logic [31:0] DEV_ASTAT  = 32'h0000_0014;
	localparam logic [31:0] DEV_BCSTAT = 32'h0000_0018;
	localparam logic [31:0] DEV_PADDR  = 32'h0000_001c;
	localparam logic [31:0] DEV_ENTRY  = 32'h0000_0020;
	localparam logic [31:0] DEV_SWFLAG = 32'h0000_0024;
	localparam int RDY_BIT  = 15;
	localparam int DBF_BIT  = 10;
	localparam int LOCK_BIT = 4;
	localparam int BLANK_CHECK_RESULT_BIT_BIT = 0;
	localparam int AREA_PROGRAMMED_COMPLETION_FLAG_BIT = 0;
	localparam int TAG_LO   = 1;
	localparam int TAG_HI   = 4;
	localparam int AREA_SHIFT = 12;
	localparam logic [31:0] ENTRY_PE = 32'h0000_0080;
	localparam logic [31:0] ENTRY_RD = 32'h0000_0000;
	// command codes
	localparam logic [7:0] CODE_BCHK  = 8'h71;
	localparam logic [7:0] CODE_PERS  = 8'h47;
	localparam logic [7:0] CODE_SWERS = 8'h87;
	localparam logic [7:0] CODE_TAGER = 8'h89;
	localparam logic [7:0] CODE_TAGUP = 8'h83;
	localparam logic [7:0] CODE_FINAL = 8'hd0;
	localparam logic [7:0] CODE_FSTOP = 8'hf0;
	localparam logic [7:0] CODE_PPRG  = 8'he0;
	localparam logic [7:0] CODE_SWPRG = 8'he1;
	localparam logic [7:0] PRG_WORDS  = 8'h08;
	localparam logic [2:0] LAST_IDX   = 3'h7;
	// own register map
	localparam logic [7:0] SW_CTRL  = 8'h00;
	localparam logic [7:0] SW_SADDR = 8'h04;
	localparam logic [7:0] SW_EADDR = 8'h08;
	localparam logic [7:0] SW_DIR   = 8'h0c;
	localparam logic [7:0] SW_STAT  = 8'h10;
	localparam logic [7:0] SW_PADDR = 8'h14;
	localparam logic [7:0] SW_DATA  = 8'h20;
	localparam int GO_BIT = 8;
	typedef enum logic [2:0] {OP_FSTOP, OP_BCHK, OP_PPRG, OP_PERS,
		OP_SWERS, OP_SWPRG, OP_TAGERS, OP_TAGUPD} fcs_op_type;
	typedef struct packed {
		logic        we;
		logic        re;
		logic [31:0] addr;
		logic [31:0] wdata;
	} fcs_dreq_type;
	typedef struct packed {
		logic        we;
		logic        re;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} fcs_sreq_type;
endpackage : fcs_pkg

// >>> verification/fcs_dev_model.sv
// behavioural flash sequencer device seen by the host controller
`timescale 1ns/100ps
module fcs_dev_model (
	input  wire logic                  clk_in,     // clock
	input  wire logic                  reset_n_in, // async reset, low
	input  wire fcs_pkg::fcs_dreq_type req_in,     // host access
	output logic [31:0]                rdata_out,  // read data
	input  wire logic                  stall_in,   // never finish
	input  wire logic                  nonblank_in, // check finds data
	input  wire logic                  lock_in,    // lock pulse
	input  wire logic [31:0]           nb_addr_in, // first nonblank address
	input  wire logic [31:0]           swflag_in,  // switch flags
	output logic [7:0]                 first_out,  // first code seen
	output logic [7:0]                 last_out,   // final code seen
	output logic [3:0]                 words_out,  // data words seen
	output logic [3:0]                 reads_out,  // window reads
	output logic [3:0]                 stops_out,  // forced stops
	output logic [31:0]                word_out    // last data word
);
	logic [31:0] entry_q, sa_q, ea_q, dir_q, rq_q;
	logic        rv_q, rdy_q, lock_q, dbf_q;
	logic [1:0]  ph_q;
	logic [2:0]  bcnt_q;
	logic [7:0]  c;
	logic        bad;
	assign c = req_in.wdata[7:0];
	assign bad = (first_out == 8'h71) && (dir_q[0] ? sa_q < ea_q : sa_q > ea_q);
	assign rdata_out = rv_q ? rq_q : ~rq_q;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			{entry_q, sa_q, ea_q, dir_q, rq_q, word_out} <= '0;
			{rv_q, lock_q, dbf_q, ph_q, bcnt_q} <= '0;
			rdy_q <= 1'b1;
			{first_out, last_out, words_out, reads_out, stops_out} <= '0;
		end else begin
			rv_q <= req_in.re;
			dbf_q <= 1'b0;
			if (lock_in)
				lock_q <= 1'b1;
			if (!rdy_q && !stall_in && bcnt_q != 3'h0) begin
				bcnt_q <= bcnt_q - 3'h1;
				rdy_q <= (bcnt_q == 3'h1);
			end
			if (req_in.re) begin
				case (req_in.addr)
					fcs_pkg::DEV_FSTAT:  rq_q <= {16'h0, rdy_q, 4'h0, dbf_q, 10'h0};
					fcs_pkg::DEV_ASTAT:  rq_q <= {27'h0, lock_q, 4'h0};
					fcs_pkg::DEV_BCSTAT: rq_q <= {31'h0, nonblank_in};
					fcs_pkg::DEV_PADDR:  rq_q <= nb_addr_in;
					fcs_pkg::DEV_SWFLAG: rq_q <= swflag_in;
					fcs_pkg::DEV_CMDWIN: begin
						rq_q <= 32'hffff_ffff;
						lock_q <= 1'b1;
						reads_out <= reads_out + 4'h1;
					end
					default: rq_q <= 32'h0;
				endcase
			end
			if (req_in.we) begin
				case (req_in.addr)
					fcs_pkg::DEV_ENTRY: entry_q <= req_in.wdata;
					fcs_pkg::DEV_SADDR: sa_q <= req_in.wdata;
					fcs_pkg::DEV_EADDR: ea_q <= req_in.wdata;
					fcs_pkg::DEV_BCCTL: dir_q <= req_in.wdata;
					fcs_pkg::DEV_CMDWIN: begin
						if (c == 8'hf0) begin
							{rdy_q, lock_q, ph_q, bcnt_q} <= {1'b1, 1'b0, 2'h0, 3'h0};
							stops_out <= stops_out + 4'h1;
						end else if (ph_q == 2'h0) begin
							first_out <= c;
							words_out <= 4'h0;
							ph_q <= (c == 8'he0 || c == 8'he1) ? 2'h2 : 2'h1;
						end else if (ph_q == 2'h2) begin
							ph_q <= 2'h3;
						end else if (ph_q == 2'h3 && words_out != 4'h8) begin
							word_out <= req_in.wdata;
							words_out <= words_out + 4'h1;
							dbf_q <= 1'b1;
						end else begin
							last_out <= c;
							ph_q <= 2'h0;
							if (c != 8'hd0 || lock_q || entry_q == 32'h0 || bad)
								lock_q <= 1'b1;
							else
								{rdy_q, bcnt_q} <= {1'b0, 3'h4};
						end
					end
					default: ;
				endcase
			end
		end
	end
endmodule : fcs_dev_model

// >>> verification/fcs_host_bench.sv
// self-checking bench of the host controller against the device model
`timescale 1ns/100ps
module fcs_host_bench;
	logic                  clk_in, reset_n_in, stall, nonblank, lock_p;
	fcs_pkg::fcs_sreq_type sw_q;
	fcs_pkg::fcs_dreq_type dreq;
	logic [31:0]           sw_rdata, drdata, rdat, swflag, nb_addr;
	logic [7:0]            first, last;
	logic [3:0]            words, reads, stops;
	logic [31:0]           word;
	int                    num_errors, compares, cyc, k;
	logic [2:0]            ops [4] = '{3'h3, 3'h4, 3'h6, 3'h7};
	logic [7:0]            codes [4] = '{8'h47, 8'h87, 8'h89, 8'h83};
	fcs_host #(.POLL_LIMIT(20'd4)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .sw_req_in(sw_q),
		.sw_rdata_out(sw_rdata), .dev_req_out(dreq), .dev_rdata_in(drdata));
	fcs_dev_model dev (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(dreq), .rdata_out(drdata),
		.stall_in(stall), .nonblank_in(nonblank), .lock_in(lock_p), .nb_addr_in(nb_addr),
		.swflag_in(swflag), .first_out(first), .last_out(last), .words_out(words),
		.reads_out(reads), .stops_out(stops), .word_out(word));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic tally_and_finish;
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors = num_errors + 1;
			tally_and_finish();
		end
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares = compares + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		sw_q <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
		@(posedge clk_in);
		sw_q.we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		sw_q <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk_in);
		sw_q.re <= 1'b0;
		#1 rdat = sw_rdata;
	endtask : rd
	task automatic run(input logic [2:0] op, input logic [31:0] exp);
		wr(fcs_pkg::SW_CTRL, 32'h100 | {29'h0, op});
		for (int i = 0; i < 3000; i++) begin
			rd(fcs_pkg::SW_STAT);
			if (rdat[0] === 1'b0)
				break;
		end
		chk("status", exp, rdat & 32'h3f);
	endtask : run
	task automatic range(input logic [31:0] s, input logic [31:0] e, input logic [31:0] d);
		wr(fcs_pkg::SW_SADDR, s);
		wr(fcs_pkg::SW_EADDR, e);
		wr(fcs_pkg::SW_DIR, d);
	endtask : range
	initial begin
		{num_errors, compares} = '0;
		{stall, nonblank, lock_p} = 3'h0;
		sw_q = '0;
		swflag = 32'h1f;
		nb_addr = 32'h150;
		reset_n_in = 1'b0;
		repeat (3) @(posedge clk_in);
		reset_n_in <= 1'b1;
		rd(fcs_pkg::SW_STAT);
		chk("reset status", 32'h0, rdat);
		rd(8'hfc);
		chk("unmapped", 32'h0, rdat);
		range(32'h100, 32'h200, 32'h0);
		run(3'h1, 32'h2);
		chk("first code", 32'h71, {24'h0, first});
		chk("final code", 32'hd0, {24'h0, last});
		nonblank <= 1'b1;
		run(3'h1, 32'h22);
		rd(fcs_pkg::SW_PADDR);
		chk("nonblank addr", 32'h150, rdat);
		nonblank <= 1'b0;
		range(32'h300, 32'h200, 32'h0);
		run(3'h1, 32'h6);
		range(32'h200, 32'h300, 32'h1);
		run(3'h1, 32'h6);
		range(32'h300, 32'h200, 32'h1);
		run(3'h1, 32'h2);
		for (k = 0; k < 4; k++) begin
			run(ops[k], 32'h2);
			chk("op code", {24'h0, codes[k]}, {24'h0, first});
			chk("op final", 32'hd0, {24'h0, last});
		end
		swflag <= 32'h0;
		run(3'h4, 32'h6);
		run(3'h6, 32'h6);
		swflag <= 32'h1f;
		for (k = 0; k < 8; k++)
			wr(fcs_pkg::SW_DATA + 8'(4 * k), 32'ha000 + k);
		for (k = 0; k < 2; k++) begin
			run(3'h2 + 3'(3 * k), 32'h2);
			chk("prog code", 32'he0 + k, {24'h0, first});
			chk("prog words", 32'h8, {28'h0, words});
			chk("prog last word", 32'ha007, word);
			chk("prog final", 32'hd0, {24'h0, last});
		end
		@(posedge clk_in);
		lock_p <= 1'b1;
		@(posedge clk_in);
		lock_p <= 1'b0;
		run(3'h3, 32'h12);
		chk("stop after lock", 32'h1, {28'h0, stops});
		stall <= 1'b1;
		run(3'h1, 32'h0a);
		stall <= 1'b0;
		chk("window read", 32'h1, {28'h0, reads});
		chk("stop on timeout", 32'h2, {28'h0, stops});
		run(3'h0, 32'h2);
		chk("forced stop", 32'h3, {28'h0, stops});
		tally_and_finish();
	end
endmodule : fcs_host_bench
